// ---- inc/cod_map.svh ----
// Constants of the opcode decoder: reset values, field positions, cycle bounds.
// Assumes one machine cycle per enabled clock edge of the core clock.
`ifndef COD_MAP_SVH
`define COD_MAP_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define COD_PC_RESET 16'h0000
`define COD_BYTE_RESET 8'h00

// ****************************************************************
// Opcode field positions
// ****************************************************************
`define COD_REG_MSB 2
`define COD_REG_LSB 0
`define COD_PTR_BIT 0

// ****************************************************************
// Machine-cycle counts
// ****************************************************************
`define COD_XRAM_MIN_CYC 4'h2
`define COD_XRAM_MAX_CYC 4'h9
`define COD_GAP_MAX 4'hF

`endif

// ---- inc/cod_pkg.sv ----
// Types shared by the opcode decoder, its cycle timer and its bench.
// Assumes the constants header is compiled alongside.
package cod_pkg;

    // ****************************************************************
    // Instruction classes, operand forms and fetch phases
    // ****************************************************************
    typedef enum logic [4:0] {
        CLS_NONE                     = 5'b00000,
        CLS_ADD                      = 5'b00001,
        CLS_SUM_WITH_CARRY           = 5'b00010,
        CLS_SUBTRACT_WITH_BORROW     = 5'b00011,
        CLS_BITWISE_AND_OP           = 5'b00100,
        CLS_BITWISE_OR_OP            = 5'b00101,
        CLS_BITWISE_XOR_OP           = 5'b00110,
        CLS_ROTATE_LEFT              = 5'b00111,
        CLS_ROTATE_LEFT_THRU_CARRY   = 5'b01000,
        CLS_ROTATE_RIGHT             = 5'b01001,
        CLS_ROTATE_RIGHT_THRU_CARRY  = 5'b01010,
        CLS_NIBBLE_SWAP              = 5'b01011,
        CLS_ZERO_ACCUMULATOR         = 5'b01100,
        CLS_INVERT_ACCUMULATOR       = 5'b01101,
        CLS_COPY_BYTE                = 5'b01110,
        CLS_CODE_TABLE_READ          = 5'b01111,
        CLS_EXTERNAL_RAM_TRANSFER    = 5'b10000,
        CLS_STACK_PUSH               = 5'b10001,
        CLS_STACK_POP                = 5'b10010,
        CLS_TRADE_BYTE_WITH_ACC      = 5'b10011,
        CLS_TRADE_LOW_NIBBLE         = 5'b10100,
        CLS_LOAD_POINTER             = 5'b10101
    } cod_cls_e;

    typedef enum logic [3:0] {
        FRM_NONE            = 4'b0000,
        FRM_ACC             = 4'b0001,
        FRM_REG             = 4'b0010,
        FRM_DIR             = 4'b0011,
        FRM_IND             = 4'b0100,
        FRM_IMM             = 4'b0101,
        FRM_IMM16           = 4'b0110,
        FRM_DATA_POINTER_16 = 4'b0111,
        FRM_CODE_VIA_PTR    = 4'b1000,
        FRM_CODE_VIA_PC     = 4'b1001,
        FRM_XRAM8           = 4'b1010,
        FRM_XRAM16          = 4'b1011,
        FRM_STACK           = 4'b1100
    } cod_form_e;

    typedef enum logic [1:0] {
        PH_OPCODE = 2'b00,
        PH_BYTE1  = 2'b01,
        PH_BYTE2  = 2'b10
    } cod_phase_e;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic      known;
        cod_cls_e  cls;
        cod_form_e dst;
        cod_form_e src;
        logic [1:0] len;
        logic [3:0] cyc;
        logic      var_cyc;
        logic [2:0] reg_idx;
        logic      ptr_sel;
    } cod_info_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        cod_info_s  info;
    } cod_instr_s;

    typedef struct packed {
        cod_phase_e phase;
        logic [15:0] pc;
        logic       valid;
        cod_instr_s instr;
    } cod_state_s;

    typedef struct packed {
        logic      run;
        logic      var_c;
        logic [3:0] need;
        logic [3:0] cnt;
    } cod_timer_s;

endpackage

// ---- hw/cod_reset_sync.sv ----
// Reset release synchroniser for the opcode decoder.
// Assumes resetn is asynchronous and active low.
`timescale 1ns/10ps
module cod_reset_sync (
    input wire logic clock,
    input wire logic resetn,
    output logic rst_n
);
    logic [1:0] sync_q;

    // Assert at once, release two edges later
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync_q <= 2'h0;
        end else begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end

    assign rst_n = sync_q[1];
endmodule

// ---- hw/cod_cycle_timer.sv ----
// Machine-cycle timer: holds the next opcode fetch until an instruction's
// cycles have elapsed. Assumes start is a single-cycle pulse.
`timescale 1ns/10ps
module cod_cycle_timer
    import cod_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [3:0] cycles,
    input wire logic variable,
    input wire logic xram_ack,
    output logic done
);
    `include "cod_map.svh"

    cod_timer_s st_q;
    cod_timer_s st_d;

    always_comb begin
        // Idle counts as elapsed so the first fetch after reset is free
        if (!st_q.run) begin
            done = 1'b1;
        end else if (st_q.var_c) begin
            done = ((st_q.cnt >= `COD_XRAM_MIN_CYC) && xram_ack) ||
                   (st_q.cnt >= `COD_XRAM_MAX_CYC);
        end else begin
            done = (st_q.cnt >= st_q.need);
        end
        st_d = st_q;
        if (start) begin
            st_d.run = 1'b1;
            st_d.var_c = variable;
            st_d.need = cycles;
            st_d.cnt = 4'h1;
        end else if (st_q.run) begin
            if (done) begin
                st_d.run = 1'b0;
            end else begin
                st_d.cnt = st_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
endmodule

// ---- hw/cod_decoder.sv ----
// Opcode decoder for the accumulator core: arithmetic, logic and transfer groups.
// Assumes program memory answers fetch_req with code_valid in the same cycle.
//
// Summary of operation
// - Plain add: 2* reg, 25 direct, 26/27 indirect, 24 immediate.
// - Add with carry: 3* reg, 35 direct, 36/37 indirect, 34 immediate.
// - Subtract with borrow: 9* reg, 95 direct, 96/97 indirect, 94 immediate.
// - AND: 5*, 55, 56/57, 54 into A; 52 direct,A; 53 direct,imm.
// - OR: 4*, 45, 46/47, 44 into A; 42 direct,A; 43 direct,imm.
// - XOR: 6*, 65, 66/67, 64 into A; 62; 63 three bytes two cycles.
// - Rotates 23, 33, 03, 13 are one byte, one cycle.
// - Nibble swap C4, zero E4, invert F4: one byte, one cycle.
// - Loads into A: E* reg, E5 direct, E6/E7 indirect, 74 immediate.
// - Loads into register: F* from A, A* direct, 7* immediate.
// - Stores to direct: F5, 8*, 85 three bytes, 86/87, 75 immediate.
// - Stores to indirect: F6/F7 from A, A6/A7 direct, 76/77 immediate.
// - Opcode 90 loads the 16-bit pointer: three bytes, three cycles.
// - Code table reads 93 and 83: one byte, three cycles.
// - External RAM E0, F0, E2/E3, F2/F3: one byte, 2 to 9 cycles.
// - Push C0 and pop D0: two bytes, two cycles.
// - Trades C*, C5, C6/C7 with A; D6/D7 trades the low nibble.
// - Star low nibble 8..F selects working register 0..7.
// - Indirect forms use pointer register 0 or 1; odd opcode selects 1.
// - Immediate operands are the 8-bit bytes after the opcode.
// - A direct operand byte addresses low RAM or a special register.
`timescale 1ns/10ps
module cod_decoder (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    output logic fetch_req,
    output logic [15:0] fetch_addr,
    input wire logic code_valid,
    input wire logic [7:0] code_byte,
    input wire logic xram_ack,
    output logic instr_valid,
    output cod_pkg::cod_instr_s instr
);
    import cod_pkg::*;
    `include "cod_map.svh"

    // ****************************************************************
    // Decode table
    // ****************************************************************
    function automatic cod_info_s mk(
        input cod_cls_e c,
        input cod_form_e d,
        input cod_form_e s,
        input logic [1:0] l,
        input logic [3:0] y
    );
        cod_info_s r;
        r = '0;
        r.known = 1'b1;
        r.cls = c;
        r.dst = d;
        r.src = s;
        r.len = l;
        r.cyc = y;
        return r;
    endfunction

    function automatic cod_info_s cod_lookup(input logic [7:0] op);
        cod_info_s r;
        cod_cls_e alu;
        logic is_alu;
        logic is_logic;
        r = mk(CLS_NONE, FRM_NONE, FRM_NONE, 2'h1, 4'h1);
        r.known = 1'b0;
        alu = CLS_NONE;
        is_alu = 1'b1;
        unique case (op[7:4])
            4'h2: alu = CLS_ADD;
            4'h3: alu = CLS_SUM_WITH_CARRY;
            4'h9: alu = CLS_SUBTRACT_WITH_BORROW;
            4'h5: alu = CLS_BITWISE_AND_OP;
            4'h4: alu = CLS_BITWISE_OR_OP;
            4'h6: alu = CLS_BITWISE_XOR_OP;
            default: is_alu = 1'b0;
        endcase
        is_logic = (op[7:6] == 2'b01) && (op[5:4] != 2'b11);
        // Accumulator-destination forms share one low-nibble layout
        if (is_alu) begin
            casez (op[3:0])
                4'b1???: r = mk(alu, FRM_ACC, FRM_REG, 2'h1, 4'h1);
                4'h5: r = mk(alu, FRM_ACC, FRM_DIR, 2'h2, 4'h2);
                4'b011?: r = mk(alu, FRM_ACC, FRM_IND, 2'h1, 4'h1);
                4'h4: r = mk(alu, FRM_ACC, FRM_IMM, 2'h2, 4'h2);
                4'h2: begin
                    if (is_logic) begin
                        r = mk(alu, FRM_DIR, FRM_ACC, 2'h2, 4'h2);
                    end
                end
                4'h3: begin
                    // XOR into direct with data needs one cycle less
                    if (is_logic) begin
                        r = mk(alu, FRM_DIR, FRM_IMM, 2'h3,
                               (alu == CLS_BITWISE_XOR_OP) ? 4'h2 : 4'h3);
                    end
                end
                default: ;
            endcase
        end
        if (!r.known) begin
            unique casez (op)
                8'h23: r = mk(CLS_ROTATE_LEFT, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'h33: r = mk(CLS_ROTATE_LEFT_THRU_CARRY, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'h03: r = mk(CLS_ROTATE_RIGHT, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'h13: r = mk(CLS_ROTATE_RIGHT_THRU_CARRY, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'hC4: r = mk(CLS_NIBBLE_SWAP, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'hE4: r = mk(CLS_ZERO_ACCUMULATOR, FRM_ACC, FRM_NONE, 2'h1, 4'h1);
                8'hF4: r = mk(CLS_INVERT_ACCUMULATOR, FRM_ACC, FRM_ACC, 2'h1, 4'h1);
                8'b1110_1???: r = mk(CLS_COPY_BYTE, FRM_ACC, FRM_REG, 2'h1, 4'h1);
                8'hE5: r = mk(CLS_COPY_BYTE, FRM_ACC, FRM_DIR, 2'h2, 4'h2);
                8'b1110_011?: r = mk(CLS_COPY_BYTE, FRM_ACC, FRM_IND, 2'h1, 4'h1);
                8'h74: r = mk(CLS_COPY_BYTE, FRM_ACC, FRM_IMM, 2'h2, 4'h2);
                8'b1111_1???: r = mk(CLS_COPY_BYTE, FRM_REG, FRM_ACC, 2'h1, 4'h1);
                8'b1010_1???: r = mk(CLS_COPY_BYTE, FRM_REG, FRM_DIR, 2'h2, 4'h2);
                8'b0111_1???: r = mk(CLS_COPY_BYTE, FRM_REG, FRM_IMM, 2'h2, 4'h2);
                8'hF5: r = mk(CLS_COPY_BYTE, FRM_DIR, FRM_ACC, 2'h2, 4'h2);
                8'b1000_1???: r = mk(CLS_COPY_BYTE, FRM_DIR, FRM_REG, 2'h2, 4'h2);
                8'h85: r = mk(CLS_COPY_BYTE, FRM_DIR, FRM_DIR, 2'h3, 4'h2);
                8'b1000_011?: r = mk(CLS_COPY_BYTE, FRM_DIR, FRM_IND, 2'h2, 4'h2);
                8'h75: r = mk(CLS_COPY_BYTE, FRM_DIR, FRM_IMM, 2'h3, 4'h3);
                8'b1111_011?: r = mk(CLS_COPY_BYTE, FRM_IND, FRM_ACC, 2'h1, 4'h1);
                8'b1010_011?: r = mk(CLS_COPY_BYTE, FRM_IND, FRM_DIR, 2'h2, 4'h2);
                8'b0111_011?: r = mk(CLS_COPY_BYTE, FRM_IND, FRM_IMM, 2'h2, 4'h2);
                8'h90: r = mk(CLS_LOAD_POINTER, FRM_DATA_POINTER_16, FRM_IMM16, 2'h3, 4'h3);
                8'h93: r = mk(CLS_CODE_TABLE_READ, FRM_ACC, FRM_CODE_VIA_PTR, 2'h1, 4'h3);
                8'h83: r = mk(CLS_CODE_TABLE_READ, FRM_ACC, FRM_CODE_VIA_PC, 2'h1, 4'h3);
                8'hE0: r = mk(CLS_EXTERNAL_RAM_TRANSFER, FRM_ACC, FRM_XRAM16, 2'h1,
                              `COD_XRAM_MIN_CYC);
                8'hF0: r = mk(CLS_EXTERNAL_RAM_TRANSFER, FRM_XRAM16, FRM_ACC, 2'h1,
                              `COD_XRAM_MIN_CYC);
                8'b1110_001?: r = mk(CLS_EXTERNAL_RAM_TRANSFER, FRM_ACC, FRM_XRAM8, 2'h1,
                                     `COD_XRAM_MIN_CYC);
                8'b1111_001?: r = mk(CLS_EXTERNAL_RAM_TRANSFER, FRM_XRAM8, FRM_ACC, 2'h1,
                                     `COD_XRAM_MIN_CYC);
                8'hC0: r = mk(CLS_STACK_PUSH, FRM_STACK, FRM_DIR, 2'h2, 4'h2);
                8'hD0: r = mk(CLS_STACK_POP, FRM_DIR, FRM_STACK, 2'h2, 4'h2);
                8'b1100_1???: r = mk(CLS_TRADE_BYTE_WITH_ACC, FRM_ACC, FRM_REG, 2'h1, 4'h1);
                8'hC5: r = mk(CLS_TRADE_BYTE_WITH_ACC, FRM_ACC, FRM_DIR, 2'h2, 4'h2);
                8'b1100_011?: r = mk(CLS_TRADE_BYTE_WITH_ACC, FRM_ACC, FRM_IND, 2'h1, 4'h1);
                8'b1101_011?: r = mk(CLS_TRADE_LOW_NIBBLE, FRM_ACC, FRM_IND, 2'h1, 4'h1);
                default: ;
            endcase
        end
        r.reg_idx = op[`COD_REG_MSB:`COD_REG_LSB];
        r.ptr_sel = op[`COD_PTR_BIT];
        r.var_cyc = (r.cls == CLS_EXTERNAL_RAM_TRANSFER);
        return r;
    endfunction

    // ****************************************************************
    // Reset and cycle timer
    // ****************************************************************
    logic rst_n;
    logic tmr_done;
    logic take;
    logic opc_take;
    cod_info_s dec_now;
    cod_state_s st_q;
    cod_state_s st_d;

    cod_reset_sync u_rst (
        .clock(clock),
        .resetn(resetn),
        .rst_n(rst_n)
    );

    cod_cycle_timer u_tmr (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(opc_take),
        .cycles(dec_now.cyc),
        .variable(dec_now.var_cyc),
        .xram_ack(xram_ack),
        .done(tmr_done)
    );

    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    always_comb begin
        dec_now = cod_lookup(code_byte);
        // Operand bytes are never held back; only the next opcode waits
        fetch_req = (st_q.phase == PH_OPCODE) ? tmr_done : 1'b1;
        take = fetch_req && code_valid;
        opc_take = take && (st_q.phase == PH_OPCODE);
        st_d = st_q;
        st_d.valid = 1'b0;
        if (take) begin
            st_d.pc = st_q.pc + 16'h0001;
            unique case (st_q.phase)
                PH_OPCODE: begin
                    st_d.instr.addr = st_q.pc;
                    st_d.instr.opcode = code_byte;
                    st_d.instr.byte1 = `COD_BYTE_RESET;
                    st_d.instr.byte2 = `COD_BYTE_RESET;
                    st_d.instr.info = dec_now;
                    if (dec_now.len == 2'h1) begin
                        st_d.valid = 1'b1;
                    end else begin
                        st_d.phase = PH_BYTE1;
                    end
                end
                PH_BYTE1: begin
                    st_d.instr.byte1 = code_byte;
                    if (st_q.instr.info.len == 2'h2) begin
                        st_d.valid = 1'b1;
                        st_d.phase = PH_OPCODE;
                    end else begin
                        st_d.phase = PH_BYTE2;
                    end
                end
                PH_BYTE2: begin
                    st_d.instr.byte2 = code_byte;
                    st_d.valid = 1'b1;
                    st_d.phase = PH_OPCODE;
                end
                default: begin
                    st_d.phase = PH_OPCODE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.pc <= `COD_PC_RESET;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign fetch_addr = st_q.pc;
    assign instr_valid = st_q.valid;
    assign instr = st_q.instr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [3:0] gap_q;
    logic [3:0] last_cyc_q;
    logic last_var_q;
    logic en_opc;

    assign en_opc = opc_take && clk_en;

    // Cycles since the previous opcode was taken, saturating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= `COD_GAP_MAX;
            last_cyc_q <= 4'h1;
            last_var_q <= 1'b0;
        end else if (clk_en) begin
            if (opc_take) begin
                gap_q <= 4'h1;
                last_cyc_q <= dec_now.cyc;
                last_var_q <= dec_now.var_cyc;
            end else if (gap_q != `COD_GAP_MAX) begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_add_direct: assert property (
        en_opc && code_byte == 8'h25 |=> instr.info.cls == CLS_ADD &&
            instr.info.src == FRM_DIR && instr.info.len == 2'h2 && instr.info.cyc == 4'h2)
        else $error("add direct decoded wrongly");
    a_carry_imm: assert property (
        en_opc && code_byte == 8'h34 |=> instr.info.cls == CLS_SUM_WITH_CARRY &&
            instr.info.src == FRM_IMM && instr.info.len == 2'h2)
        else $error("add with carry immediate decoded wrongly");
    a_borrow_reg: assert property (
        en_opc && code_byte[7:3] == 5'b1001_1 |=> instr.info.cls == CLS_SUBTRACT_WITH_BORROW
            && instr.info.src == FRM_REG && instr.info.cyc == 4'h1)
        else $error("subtract register decoded wrongly");
    a_and_dir_imm: assert property (
        en_opc && code_byte == 8'h53 |=> instr.info.dst == FRM_DIR &&
            instr.info.len == 2'h3 && instr.info.cyc == 4'h3)
        else $error("and direct immediate decoded wrongly");
    a_or_dir_acc: assert property (
        en_opc && code_byte == 8'h42 |=> instr.info.cls == CLS_BITWISE_OR_OP &&
            instr.info.src == FRM_ACC && instr.info.len == 2'h2)
        else $error("or direct accumulator decoded wrongly");
    a_xor_short: assert property (
        en_opc && code_byte == 8'h63 |=> instr.info.len == 2'h3 && instr.info.cyc == 4'h2)
        else $error("xor direct immediate timing wrong");
    a_copy_dir_dir: assert property (
        en_opc && code_byte == 8'h85 |=> instr.info.len == 2'h3 && instr.info.cyc == 4'h2)
        else $error("direct to direct copy timing wrong");
    a_table_read: assert property (
        en_opc && (code_byte == 8'h93 || code_byte == 8'h83) |=>
            instr.info.cls == CLS_CODE_TABLE_READ && instr.info.cyc == 4'h3)
        else $error("code table read decoded wrongly");
    a_reg_select: assert property (
        en_opc && code_byte[3] && code_byte[7:4] == 4'hE |=>
            instr.info.src == FRM_REG && instr.info.reg_idx == $past(code_byte[2:0]))
        else $error("working register index wrong");
    a_ptr_select: assert property (
        en_opc && code_byte[7:1] == 7'b1111_011 |=> instr.info.ptr_sel == $past(code_byte[0]))
        else $error("pointer register select wrong");
    a_pc_advance: assert property (
        instr_valid |-> fetch_addr == instr.addr + {14'h0000, instr.info.len})
        else $error("program counter not advanced by length");
    a_fetch_hold: assert property (
        en_opc && !last_var_q |-> gap_q >= last_cyc_q)
        else $error("next opcode fetched too early");
    // Upper bound lives on fetch_req: a stalled code byte may delay the take itself
    a_xram_window: assert property (
        en_opc && last_var_q |-> gap_q >= 4'h2)
        else $error("external transfer shorter than 2 cycles");
    a_xram_release: assert property (
        last_var_q && gap_q >= 4'h9 && st_q.phase == PH_OPCODE |-> fetch_req)
        else $error("external transfer held past 9 cycles");
    a_issue_delay: assert property (
        en_opc && code_byte == 8'h90 && clk_en ##1 take && clk_en ##1 take && clk_en
            |=> instr_valid && instr.info.cls == CLS_LOAD_POINTER)
        else $error("pointer load not issued after three bytes");

    c_three_byte: cover property (instr_valid && instr.info.len == 2'h3);
    c_xram_ack: cover property (en_opc && last_var_q && gap_q == 4'h3);
    c_xram_timeout: cover property (en_opc && last_var_q && gap_q == 4'h9);
    c_unknown_op: cover property (instr_valid && !instr.info.known);
endmodule

// ---- test/cod_code_mem.sv ----
// Program and external RAM model facing the decoder.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module cod_code_mem (
    input wire logic clock,
    input wire logic slow,
    input wire logic [15:0] fetch_addr,
    output logic code_valid,
    output logic [7:0] code_byte,
    output logic xram_ack
);
    logic [7:0] mem [0:1023];
    initial begin
        code_valid = 1'b0;
        xram_ack = 1'b0;
    end
    always @(negedge clock) begin
        code_valid <= !slow || $urandom % 4 != 0;
        xram_ack <= !slow || $urandom % 3 == 0;
    end
    // Stalls show the inverse, so a byte taken early reads wrong
    assign code_byte = code_valid ? mem[fetch_addr[9:0]] : ~mem[fetch_addr[9:0]];
endmodule

// ---- test/tb_cod_decoder.sv ----
// Bench: every opcode once, first prompt, then with stalls.
// Assumes the code memory model beside it.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t exp %0h got %0h", $time, (b), (a)); end end
module tb_cod_decoder;
    import cod_pkg::*;
    logic clock, resetn, clk_en, slow, fetch_req, code_valid, xram_ack, instr_valid;
    logic [15:0] fetch_addr;
    logic [7:0] code_byte;
    logic [11:0] v, w;
    cod_instr_s instr;
    int err_count, cmp_count, idx, pc_e, en_cyc, last, pl, py, l, g, i, j, k, n;
    cod_decoder uut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .code_valid(code_valid),
        .code_byte(code_byte), .xram_ack(xram_ack), .instr_valid(instr_valid),
        .instr(instr));
    cod_code_mem pm (.clock(clock), .slow(slow), .fetch_addr(fetch_addr),
        .code_valid(code_valid), .code_byte(code_byte), .xram_ack(xram_ack));
    // ****
    // Reference: variable [8], bytes [7:4], cycles [3:0]
    // ****
    function automatic logic [11:0] spec(input logic [7:0] op);
        case (op)
            8'h85, 8'h63: return 12'h032;
            8'h75, 8'h53, 8'h43, 8'h90: return 12'h033;
            8'h93, 8'h83: return 12'h013;
            8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: return 12'h112;
            8'h25, 8'h35, 8'h95, 8'h24, 8'h34, 8'h94: return 12'h022;
            8'h55, 8'h45, 8'h65, 8'h54, 8'h44, 8'h64: return 12'h022;
            8'h52, 8'h42, 8'h62, 8'hE5, 8'h74, 8'hF5: return 12'h022;
            8'hC5, 8'hC0, 8'hD0: return 12'h022;
            default: return (op[3:0] > 5 && op[7:4] inside {7, 8, 10}) ? 12'h022 : 12'h011;
        endcase
    endfunction
    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(negedge clock) clk_en <= !slow || $urandom % 4 != 0;
    always @(posedge clock) begin
        if (!resetn) begin
            idx = 0;
            pc_e = 0;
            en_cyc = 0;
        end else if (clk_en) begin
            en_cyc++;
            if (instr_valid === 1'b1 && idx < 256) begin
                v = spec(idx[7:0]);
                l = v[7:4];
                `CHK({instr.addr, instr.opcode}, {pc_e[15:0], idx[7:0]})
                `CHK({instr.info.len, instr.info.cyc, instr.info.var_cyc}, {v[5:0], v[8]})
                `CHK({instr.byte1, instr.byte2}, {l > 1 ? pm.mem[pc_e + 1] : 8'h00,
                    l > 2 ? pm.mem[pc_e + 2] : 8'h00})
                `CHK({instr.info.reg_idx, instr.info.ptr_sel}, {idx[2:0], idx[0]})
                g = (py > pl ? py : pl) - pl + l;
                if (idx > 0) `CHK(slow ? en_cyc - last >= g : en_cyc - last, slow ? 1 : g)
                pl = l;
                py = v[3:0];
                last = en_cyc;
                pc_e += l;
                idx++;
            end
        end
    end
    initial begin
        void'($urandom(99809));
        resetn = 1'b0;
        slow = 1'b0;
        clk_en = 1'b1;
        k = 0;
        for (i = 0; i < 256; i++) begin
            w = spec(i[7:0]);
            pm.mem[k] = i[7:0];
            for (j = 1; j < w[7:4]; j++) pm.mem[k + j] = $urandom;
            k += w[7:4];
        end
        // Defined tail of 00, so fetches past the program decode as one-byte unknowns, not X
        for (j = k; j < 1024; j++) pm.mem[j] = 8'h00;
        for (n = 0; n < 2; n++) begin
            @(negedge clock);
            resetn = 1'b0;
            slow = n[0];
            repeat (20) @(negedge clock);
            resetn = 1'b1;
            for (k = 0; k < 20000 && idx < 256; k++) @(negedge clock);
            if (idx < 256) begin
                err_count++;
                n = 2;
            end
        end
        finish_test();
    end
endmodule
